//--- shared/eda_params.svh
// constants for the external data access timing block
`ifndef EDA_PARAMS_SVH
`define EDA_PARAMS_SVH

// ==========================================================
// register indices, byte address is four times the index
`define EDA_IDX_POINTER_SELECT 10'h086
`define EDA_IDX_CLOCK_CONTROL 10'h010
`define EDA_IDX_MEMORY_MAP 10'h011
`define EDA_IDX_TIMED_ACCESS 10'h012
`define EDA_IDX_FIRST_POINTER 10'h013
`define EDA_IDX_SECOND_POINTER 10'h014
`define EDA_IDX_WORK_REG 10'h015
`define EDA_IDX_PORT_TWO 10'h016
`define EDA_IDX_COMMAND 10'h017
`define EDA_IDX_STATUS 10'h018
`define EDA_IDX_WRITE_DATA 10'h019

// ==========================================================
// field positions
`define EDA_STRETCH_MSB 2
`define EDA_WAIT_ENABLE_BIT 7
`define EDA_CMD_START_BIT 0
`define EDA_CMD_WRITE_BIT 1
`define EDA_CMD_INDIRECT_BIT 2
`define EDA_CMD_INCR_BIT 3

// ==========================================================
// reset values
`define EDA_CLOCK_CONTROL_RST 8'h01
`define EDA_MEMORY_MAP_RST 8'h00

// ==========================================================
// timing and protection counts
`define EDA_CLK_PER_MCYC 4
`define EDA_TA_KEY1 8'hAA
`define EDA_TA_KEY2 8'h55
`define EDA_TA_WINDOW 3'h4
`define EDA_RESP_OKAY 2'h0
`define EDA_RESP_SLVERR 2'h2

`endif

//--- shared/eda_pkg.sv
// types for the external data access timing block
`default_nettype none

package eda_pkg;

	// ==========================================================
	// access sequencer states
	typedef enum logic [1:0] {EDA_IDLE, EDA_FETCH, EDA_ACCESS} eda_state_t;

	// ==========================================================
	// external bus pins, driven as one group
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] dataOut;
		logic dataOe_n;
		logic rd_n;
		logic wr_n;
	} eda_ext_t;

	// ==========================================================
	// one queued access request
	typedef struct packed {
		logic write;
		logic indirect;
		logic incr;
	} eda_cmd_t;

endpackage

`default_nettype wire

//--- hdl/eda_ext_data_access.sv
// external data move timing controller with stretch, wait states and dual pointers
// ==========================================================
// Summary of operation
// - four-clock fetch, then address and access cycle
// - stretch field is clock control bits 2..0
// - stretch zero..seven gives two..nine machine cycles
// - stretching never alters other instruction timing
// - stretch resets to one; zero is fastest
// - strobe width 2,4,8..28 clocks per stretch
// - wait pin exists only on larger package
// - wait honoured only when wait enable set
// - wait sampled in state three before strobe ends
// - each recognised wait adds one machine cycle
// - unlimited waits; ends once peripheral drops wait
// - wait enable writable only via timed access
// - pointer select picks first or second pointer
// - pointer select is bit zero, others zero
// - indirect: low from work reg, high port two
// - machine cycle is four states, one..four
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "eda_params.svh"

module eda_ext_data_access
	import eda_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite write channels
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// external data bus
	output eda_ext_t extBus,
	input wire logic [7:0] extDataIn,
	input wire logic portFourBitZero
);

	// ==========================================================
	// functions
	function automatic logic [7:0] strobeWidth(input logic [2:0] s);
		strobeWidth = (s == 3'h0) ? 8'h02 : {3'h0, s, 2'h0};
	endfunction

	function automatic logic [9:0] regIndex(input logic [11:0] a);
		regIndex = a[11:2];
	endfunction

	// ==========================================================
	// registers and state
	eda_state_t state;
	logic [1:0] phase;
	logic [7:0] clockControl;
	logic [7:0] memoryMapControl;
	logic pointerSelect;
	logic [15:0] firstDataPointer;
	logic [15:0] secondDataPointer;
	logic [7:0] workReg;
	logic [7:0] portTwo;
	logic [7:0] writeData;
	logic [7:0] readData;
	logic [1:0] taStage;
	logic [2:0] taWindow;
	logic pending;
	eda_cmd_t pendCmd;
	eda_cmd_t accCmd;
	logic [2:0] accStretch;
	logic accPointer;
	logic [15:0] accAddr;
	logic [3:0] cycLeft;
	logic firstCyc;
	logic waitHold;
	logic [1:0] waitSync;
	logic [7:0] dataSync1;
	logic [7:0] dataSync2;
	logic awHeld;
	logic wHeld;
	logic [11:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;

	// ==========================================================
	// decode
	wire logic [2:0] stretchField = clockControl[`EDA_STRETCH_MSB:0];
	wire logic waitOn = LARGE_PACKAGE && memoryMapControl[`EDA_WAIT_ENABLE_BIT];
	wire logic wrFire = awHeld && wHeld && !s_axi_bvalid;
	wire logic [9:0] wrIdx = regIndex(awAddr);
	wire logic lane0 = wrFire && wStrb[0];
	wire logic lane1 = wrFire && wStrb[1];
	wire logic hitClock = lane0 && wrIdx == `EDA_IDX_CLOCK_CONTROL;
	wire logic hitMap = lane0 && wrIdx == `EDA_IDX_MEMORY_MAP;
	wire logic hitTa = lane0 && wrIdx == `EDA_IDX_TIMED_ACCESS;
	wire logic hitSelect = lane0 && wrIdx == `EDA_IDX_POINTER_SELECT;
	wire logic hitWork = lane0 && wrIdx == `EDA_IDX_WORK_REG;
	wire logic hitPort = lane0 && wrIdx == `EDA_IDX_PORT_TWO;
	wire logic hitWdata = lane0 && wrIdx == `EDA_IDX_WRITE_DATA;
	wire logic hitFirstLo = lane0 && wrIdx == `EDA_IDX_FIRST_POINTER;
	wire logic hitFirstHi = lane1 && wrIdx == `EDA_IDX_FIRST_POINTER;
	wire logic hitSecondLo = lane0 && wrIdx == `EDA_IDX_SECOND_POINTER;
	wire logic hitSecondHi = lane1 && wrIdx == `EDA_IDX_SECOND_POINTER;
	wire logic busy = pending || state != EDA_IDLE;
	wire logic hitCmd = lane0 && wrIdx == `EDA_IDX_COMMAND
		&& wData[`EDA_CMD_START_BIT] && !busy;
	wire logic taOpen = taWindow != 3'h0;
	wire logic wrMapped = wrIdx == `EDA_IDX_CLOCK_CONTROL || wrIdx == `EDA_IDX_MEMORY_MAP
		|| wrIdx == `EDA_IDX_TIMED_ACCESS || wrIdx == `EDA_IDX_POINTER_SELECT
		|| wrIdx == `EDA_IDX_WORK_REG || wrIdx == `EDA_IDX_PORT_TWO
		|| wrIdx == `EDA_IDX_WRITE_DATA || wrIdx == `EDA_IDX_FIRST_POINTER
		|| wrIdx == `EDA_IDX_SECOND_POINTER || wrIdx == `EDA_IDX_COMMAND
		|| wrIdx == `EDA_IDX_STATUS;
	wire logic [9:0] rdIdx = regIndex(s_axi_araddr);
	wire logic [15:0] selPointer = pointerSelect ? secondDataPointer : firstDataPointer;
	wire logic [15:0] launchAddr = pendCmd.indirect ? {portTwo, workReg} : selPointer;
	wire logic lastCyc = cycLeft == 4'h1 && !waitHold;
	wire logic [1:0] startPh = (accStretch == 3'h0) ? 2'h1 : 2'h3;
	wire logic afterStart = !firstCyc || phase >= startPh;
	wire logic beforeEnd = !lastCyc || phase != 2'h3;
	wire logic strobeAct = state == EDA_ACCESS && afterStart && beforeEnd;
	wire logic waitSeen = state == EDA_ACCESS && phase == 2'h2 && cycLeft == 4'h1
		&& waitOn && waitSync[1];
	wire logic accDone = state == EDA_ACCESS && phase == 2'h3 && lastCyc;
	logic [31:0] rdMux;
	logic rdMapped;
	eda_state_t next_state;

	always_comb
	begin
		rdMapped = 1'b1;
		unique case (rdIdx)
			`EDA_IDX_CLOCK_CONTROL: rdMux = {24'h0, clockControl};
			`EDA_IDX_MEMORY_MAP: rdMux = {24'h0, memoryMapControl};
			`EDA_IDX_POINTER_SELECT: rdMux = {31'h0, pointerSelect};
			`EDA_IDX_FIRST_POINTER: rdMux = {16'h0, firstDataPointer};
			`EDA_IDX_SECOND_POINTER: rdMux = {16'h0, secondDataPointer};
			`EDA_IDX_WORK_REG: rdMux = {24'h0, workReg};
			`EDA_IDX_PORT_TWO: rdMux = {24'h0, portTwo};
			`EDA_IDX_WRITE_DATA: rdMux = {24'h0, writeData};
			`EDA_IDX_STATUS: rdMux = {16'h0, readData, 6'h0, waitSync[1], busy};
			`EDA_IDX_TIMED_ACCESS, `EDA_IDX_COMMAND: rdMux = 32'h0;
			default:
			begin
				rdMux = 32'h0;
				rdMapped = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			EDA_IDLE: if (pending && phase == 2'h3) next_state = EDA_FETCH;
			EDA_FETCH: if (phase == 2'h3) next_state = EDA_ACCESS;
			EDA_ACCESS: if (accDone) next_state = EDA_IDLE;
		endcase
	end

	// ==========================================================
	// axi4-lite handshakes
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 12'h000;
			wData <= 32'h0;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (wrFire)
			begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? `EDA_RESP_OKAY : `EDA_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdMapped ? `EDA_RESP_OKAY : `EDA_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// software registers and timed access
	// the window closes after one protected write so a stray second write cannot slip in
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			clockControl <= `EDA_CLOCK_CONTROL_RST;
			memoryMapControl <= `EDA_MEMORY_MAP_RST;
			pointerSelect <= 1'b0;
			workReg <= 8'h00;
			portTwo <= 8'h00;
			writeData <= 8'h00;
			taStage <= 2'h0;
			taWindow <= 3'h0;
		end
		else
		begin
			if (hitClock) clockControl <= wData[7:0];
			if (hitSelect) pointerSelect <= wData[0];
			if (hitWork) workReg <= wData[7:0];
			if (hitPort) portTwo <= wData[7:0];
			if (hitWdata) writeData <= wData[7:0];
			if (hitMap)
				memoryMapControl <= {taOpen ? wData[7] : memoryMapControl[7], wData[6:0]};
			if (hitTa)
				taStage <= (wData[7:0] == `EDA_TA_KEY1) ? 2'h1 : 2'h0;
			if (hitTa && taStage == 2'h1 && wData[7:0] == `EDA_TA_KEY2)
				taWindow <= `EDA_TA_WINDOW;
			else if (hitMap)
				taWindow <= 3'h0;
			else if (taOpen)
				taWindow <= taWindow - 3'h1;
		end
	end

	// ==========================================================
	// data pointers; software write wins over an increment in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			firstDataPointer <= 16'h0000;
			secondDataPointer <= 16'h0000;
		end
		else
		begin
			if (accDone && accCmd.incr && !accPointer)
				firstDataPointer <= firstDataPointer + 16'h0001;
			if (accDone && accCmd.incr && accPointer)
				secondDataPointer <= secondDataPointer + 16'h0001;
			if (hitFirstLo) firstDataPointer[7:0] <= wData[7:0];
			if (hitFirstHi) firstDataPointer[15:8] <= wData[15:8];
			if (hitSecondLo) secondDataPointer[7:0] <= wData[7:0];
			if (hitSecondHi) secondDataPointer[15:8] <= wData[15:8];
		end
	end

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			waitSync <= 2'h0;
			dataSync1 <= 8'h00;
			dataSync2 <= 8'h00;
		end
		else
		begin
			waitSync <= {waitSync[0], portFourBitZero};
			dataSync1 <= extDataIn;
			dataSync2 <= dataSync1;
		end
	end

	// ==========================================================
	// machine cycle sequencer; the phase counter never stalls, so other timing is untouched
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= EDA_IDLE;
			phase <= 2'h0;
			pending <= 1'b0;
			pendCmd <= '0;
			accCmd <= '0;
			accStretch <= 3'h0;
			accPointer <= 1'b0;
			accAddr <= 16'h0000;
			cycLeft <= 4'h0;
			firstCyc <= 1'b0;
			waitHold <= 1'b0;
			readData <= 8'h00;
		end
		else
		begin
			state <= next_state;
			phase <= phase + 2'h1;
			if (hitCmd)
			begin
				pending <= 1'b1;
				pendCmd <= '{write: wData[`EDA_CMD_WRITE_BIT],
					indirect: wData[`EDA_CMD_INDIRECT_BIT], incr: wData[`EDA_CMD_INCR_BIT]};
			end
			if (state == EDA_IDLE && next_state == EDA_FETCH)
			begin
				pending <= 1'b0;
				accCmd <= pendCmd;
				accPointer <= pointerSelect;
				accAddr <= launchAddr;
			end
			if (state == EDA_FETCH && phase == 2'h3)
			begin
				accStretch <= stretchField;
				cycLeft <= {1'b0, stretchField} + 4'h1;
				firstCyc <= 1'b1;
			end
			if (waitSeen) waitHold <= 1'b1;
			if (state == EDA_ACCESS && phase == 2'h3)
			begin
				firstCyc <= 1'b0;
				waitHold <= 1'b0;
				if (!waitHold && cycLeft != 4'h1) cycLeft <= cycLeft - 4'h1;
				if (accDone && !accCmd.write) readData <= dataSync2;
			end
		end
	end

	// ==========================================================
	// external pins; the peripheral keeps the wait level until it is ready
	assign extBus.addr = accAddr;
	assign extBus.dataOut = writeData;
	assign extBus.dataOe_n = !(state == EDA_ACCESS && accCmd.write);
	assign extBus.rd_n = !(strobeAct && !accCmd.write);
	assign extBus.wr_n = !(strobeAct && accCmd.write);

	// ==========================================================
	// checks
	logic [7:0] strobeCnt;
	logic [7:0] waitCnt;
	logic [9:0] instrClk;
	always_ff @(posedge clk)
	begin
		if (!rst_n || state == EDA_IDLE)
		begin
			strobeCnt <= 8'h00;
			waitCnt <= 8'h00;
			instrClk <= 10'h000;
		end
		else
		begin
			strobeCnt <= strobeCnt + {7'h0, strobeAct};
			waitCnt <= waitCnt + {7'h0, waitSeen};
			instrClk <= instrClk + 10'h001;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	fetch_len_a: assert property ((state == EDA_FETCH && $past(state) == EDA_IDLE) |->
		(state == EDA_FETCH)[*4] ##1 state == EDA_ACCESS) else $error("fetch not four clocks");
	instr_len_a: assert property (accDone |->
		instrClk + 10'h001 == {3'h0, 5'({2'h0, accStretch} + 5'h02) + waitCnt[4:0], 2'h0})
		else $error("access length wrong");
	strobe_width_a: assert property ($fell(strobeAct) |->
		strobeCnt == strobeWidth(accStretch) + {waitCnt[5:0], 2'h0}) else $error("strobe width wrong");
	stretch_reset_a: assert property ($rose(rst_n) |-> stretchField == 3'h1)
		else $error("stretch reset not one");
	phase_free_a: assert property ($past(rst_n) |-> phase == 2'($past(phase) + 2'h1))
		else $error("phase stalled");
	wait_gate_a: assert property ((!waitOn && state == EDA_ACCESS) |=> !waitHold)
		else $error("wait honoured while off");
	wait_extend_a: assert property (waitSeen |=> ##1 state == EDA_ACCESS && strobeAct)
		else $error("wait did not extend");
	addr_stable_a: assert property ((state == EDA_ACCESS && $past(state) == EDA_ACCESS) |->
		$stable(extBus.addr)) else $error("address moved in access");
	strobe_idle_a: assert property (state != EDA_ACCESS |-> extBus.rd_n && extBus.wr_n)
		else $error("strobe outside access");
	ta_guard_a: assert property ((hitMap && !taOpen) |=> $stable(memoryMapControl[7]))
		else $error("wait enable changed unprotected");
	pointer_pick_a: assert property ((state == EDA_IDLE && next_state == EDA_FETCH &&
		!pendCmd.indirect) |=> accAddr == $past(selPointer)) else $error("wrong pointer used");

	read_cover_c: cover property (accDone && !accCmd.write);
	write_wait_c: cover property (waitSeen ##[1:8] accDone && accCmd.write);
	fast_access_c: cover property (accDone && accStretch == 3'h0);

endmodule // eda_ext_data_access

`default_nettype wire

//--- verif/eda_ext_ram.sv
// behavioural external data memory with a wait pin
`timescale 1ns/1ns
`default_nettype none

module eda_ext_ram
	import eda_pkg::*;
(
	// clock
	input wire logic clk,
	// device side
	input wire eda_ext_t extBus,
	output logic [7:0] extDataIn,
	output logic portFourBitZero,
	// bench control: clocks of wait per strobe
	input wire logic [4:0] holdClks
);
	// ==========================================================
	// storage and bus
	logic [7:0] mem [0:255];
	logic [7:0] lastOut = 8'h00;
	logic [5:0] lowCnt = 6'h00;
	logic waitPin = 1'b0;
	wire logic strobeLow = !extBus.rd_n || !extBus.wr_n;
	integer i;

	initial
	begin
		for (i = 0; i < 256; i++)
			mem[i] = ~i[7:0];
	end

	always @(posedge clk)
	begin
		if (!extBus.wr_n && !extBus.dataOe_n)
			mem[extBus.addr[7:0]] <= extBus.dataOut;
		if (!extBus.rd_n)
			lastOut <= mem[extBus.addr[7:0]];
		lowCnt <= strobeLow ? lowCnt + 6'h01 : 6'h00;
		// holds wait until it is ready, then drops it for good
		waitPin <= strobeLow && (lowCnt < {1'b0, holdClks});
	end

	// a released bus shows the inverse, so a late sample cannot pass by luck
	assign extDataIn = extBus.rd_n ? ~lastOut : mem[extBus.addr[7:0]];
	assign portFourBitZero = waitPin;
endmodule // eda_ext_ram

`default_nettype wire

//--- verif/ext_data_access_stretch_wait_tb.sv
// self-checking bench for the external data access timing block
`timescale 1ns/1ns
`default_nettype none
`include "eda_params.svh"

module ext_data_access_stretch_wait_tb
	import eda_pkg::*;
;
	// ==========================================================
	// signals
	logic clk, rst_n, awValid, awReady, wValid, wReady, bValid, arValid, arReady, rValid;
	logic [11:0] awAddr, arAddr;
	logic [31:0] wData, rData, d;
	logic [1:0] bResp, rResp, r;
	eda_ext_t extBus;
	logic [7:0] extDataIn;
	logic waitPin;
	logic [4:0] holdClks;
	int fails = 0, n_tests = 0, nStrobe = 0, s;
	logic [7:0] lead = 8'h00, width = 8'h00, lowCnt = 8'h00, sinceAddr = 8'h00;
	logic [15:0] prevAddr = 16'h0000, strAddr = 16'h0000;
	logic wasLow = 1'b0, addrMoved = 1'b0;
	wire logic strobeLow = !extBus.rd_n || !extBus.wr_n;
	int ws [3] = '{1, 2, 1};
	int wh [3] = '{6, 6, 14};
	int wk [3] = '{2, 1, 4};

	eda_ext_data_access dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(1'b1), .extBus(extBus), .extDataIn(extDataIn),
		.portFourBitZero(waitPin));

	eda_ext_ram ram (.clk(clk), .extBus(extBus), .extDataIn(extDataIn),
		.portFourBitZero(waitPin), .holdClks(holdClks));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// strobe monitor: lead from address change, width, address hold
	always @(posedge clk)
	begin
		prevAddr <= extBus.addr;
		sinceAddr <= (extBus.addr != prevAddr) ? 8'h01 : sinceAddr + 8'h01;
		wasLow <= strobeLow;
		if (strobeLow && !wasLow)
		begin
			lead <= sinceAddr;
			lowCnt <= 8'h01;
			strAddr <= extBus.addr;
		end
		else if (strobeLow)
		begin
			lowCnt <= lowCnt + 8'h01;
			if (extBus.addr !== strAddr)
				addrMoved <= 1'b1;
		end
		if (!strobeLow && wasLow)
		begin
			width <= lowCnt;
			nStrobe <= nStrobe + 1;
		end
	end

	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic axw(input logic [9:0] idx, input logic [31:0] v);
		int i;
		awAddr <= {idx, 2'b00};
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		r = 2'h3;
		for (i = 0; i < 50 && r === 2'h3; i++)
		begin
			@(posedge clk);
			if (awReady)
				awValid <= 1'b0;
			if (wReady)
				wValid <= 1'b0;
			if (bValid)
				r = bResp;
		end
		if (r === 2'h3)
			fails++;
	endtask

	task automatic axr(input logic [9:0] idx);
		int i;
		arAddr <= {idx, 2'b00};
		arValid <= 1'b1;
		r = 2'h3;
		d = 32'hXXXXXXXX;
		for (i = 0; i < 50 && r === 2'h3; i++)
		begin
			@(posedge clk);
			if (arReady)
				arValid <= 1'b0;
			if (rValid)
			begin
				d = rData;
				r = rResp;
			end
		end
		if (r === 2'h3)
			fails++;
	endtask

	// one access: s stretch, k wait cycles expected, ed read data
	task automatic acc(input logic [31:0] cmd, input logic [15:0] ea, input int s,
		input int k, input logic [7:0] ed);
		int i;
		int n0;
		n0 = nStrobe;
		axw(`EDA_IDX_COMMAND, cmd);
		for (i = 0; i < 400 && nStrobe == n0; i++)
			@(posedge clk);
		if (nStrobe == n0)
			fails++;
		d = 32'h1;
		for (i = 0; i < 10 && d[0] !== 1'b0; i++)
			axr(`EDA_IDX_STATUS);
		chk({31'h0, d[0]}, 32'h0);
		chk(strAddr, ea);
		chk(width, 32'((s == 0 ? 2 : 4 * s) + 4 * k));
		chk(lead, 32'(s == 0 ? 5 : 7));
		chk(32'(lead) + 32'(width) + 32'h1, 32'(4 * (s + 2 + k)));
		if (!cmd[1])
			chk(d[15:8], ed);
	endtask

	task automatic final_report;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================================
	// sequence
	initial
	begin
		rst_n = 1'b0;
		awValid = 1'b0;
		wValid = 1'b0;
		arValid = 1'b0;
		awAddr = 12'h000;
		arAddr = 12'h000;
		wData = 32'h0;
		holdClks = 5'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		axr(`EDA_IDX_CLOCK_CONTROL);
		chk(d, 32'h1);
		axr(`EDA_IDX_MEMORY_MAP);
		chk(d, 32'h0);
		axw(`EDA_IDX_POINTER_SELECT, 32'hFF);
		axr(`EDA_IDX_POINTER_SELECT);
		chk(d, 32'h1);
		axw(`EDA_IDX_POINTER_SELECT, 32'h0);
		axr(10'h3FF);
		chk({d[29:0], r}, 32'h2);
		axw(10'h3FF, 32'h0);
		chk({30'h0, r}, 32'h2);
		axw(`EDA_IDX_FIRST_POINTER, 32'h1230);
		acc(32'h9, 16'h1230, 1, 0, 8'hCF);
		for (s = 0; s < 8; s++)
		begin
			axw(`EDA_IDX_CLOCK_CONTROL, s);
			axr(`EDA_IDX_CLOCK_CONTROL);
			chk(d, s);
			acc(32'h9, 16'h1231 + s[15:0], s, 0, ~(8'h31 + s[7:0]));
		end
		axr(`EDA_IDX_FIRST_POINTER);
		chk(d, 32'h1239);
		axw(`EDA_IDX_SECOND_POINTER, 32'h4321);
		axw(`EDA_IDX_POINTER_SELECT, 32'h1);
		axw(`EDA_IDX_WRITE_DATA, 32'hA5);
		acc(32'h3, 16'h4321, 7, 0, 8'h00);
		axw(`EDA_IDX_PORT_TWO, 32'hAB);
		axw(`EDA_IDX_WORK_REG, 32'hCD);
		acc(32'h5, 16'hABCD, 7, 0, 8'h32);
		acc(32'h1, 16'h4321, 7, 0, 8'hA5);
		axw(`EDA_IDX_POINTER_SELECT, 32'h0);
		axw(`EDA_IDX_CLOCK_CONTROL, 32'h1);
		holdClks <= 5'h06;
		acc(32'h9, 16'h1239, 1, 0, 8'hC6);
		axw(`EDA_IDX_MEMORY_MAP, 32'h80);
		axr(`EDA_IDX_MEMORY_MAP);
		chk(d, 32'h0);
		axw(`EDA_IDX_TIMED_ACCESS, 32'hAA);
		axw(`EDA_IDX_TIMED_ACCESS, 32'h55);
		axw(`EDA_IDX_MEMORY_MAP, 32'h80);
		axr(`EDA_IDX_MEMORY_MAP);
		chk(d, 32'h80);
		// wait pin held past the stretch: cycles added one per sampled wait
		for (s = 0; s < 3; s++)
		begin
			axw(`EDA_IDX_CLOCK_CONTROL, ws[s]);
			holdClks <= wh[s][4:0];
			acc(32'h9, 16'h123A + s[15:0], ws[s], wk[s], ~(8'h3A + s[7:0]));
		end
		// a write held off by the wait pin as well
		holdClks <= 5'h06;
		acc(32'hB, 16'h123D, 1, 2, 8'h00);
		holdClks <= 5'h00;
		chk(addrMoved, 32'h0);
		final_report;
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		fails++;
		final_report;
	end
endmodule // ext_data_access_stretch_wait_tb

`default_nettype wire
